// ==== core/tracked_supply_sequencing.sv ====
// Tracked supply sequencer with chip-wide configuration register
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Software turns master on after all slaves and off before them.
// RULE2: Slave run output stays asserted while it tracks down.
// RULE3: Software extends slave rise time to end after the tracking reference rises.
// RULE4: Tracked channels sequence down on fault, low input, timebase low or restore.
// RULE5: Tracked channels mask undervoltage and undercurrent during off delay.
// RULE6: Undervoltage and undercurrent always masked during rise and max-rise intervals.
// RULE7: Master untracked, slaves tracked, slave delays include master delays.
// RULE8: Software keeps setup margins between master and slave delays.
// RULE9: Chip-wide configuration register is reachable regardless of page.
// RULE10: Upper four bits of chip-wide configuration read as zero.
// RULE11: Source bit clear: power-good follows slow converter threshold compare.
// RULE12: Source bit set: power-good follows fast undervoltage supervisor.
// RULE13: Bit nine selects active level of start pin three.
// RULE14: Bit eight selects active level of start pin two.
// RULE15: One track-enable bit per channel marks it a tracked slave.
// RULE16: Writes to reserved configuration bits are ignored.
module tracked_supply_sequencing
	import track_seq_pkg::*;
(
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	input  wire logic                          cfgWrEn,
	input  wire logic [REG_W-1:0]              cfgWrData,
	input  wire logic                          trackWrEn,
	input  wire logic [NUM_CH-1:0]             trackWrData,
	input  wire logic [NUM_CH-1:0]             softOnReq,
	input  wire logic                          start_pin_2,
	input  wire logic                          start_pin_3,
	input  wire logic                          shareClkPin,
	input  wire logic                          vinOff,
	input  wire logic                          restoreAll,
	input  wire logic [NUM_CH-1:0]             chanFault,
	input  wire logic [NUM_CH-1:0]             voutAboveUv,
	input  wire logic [NUM_CH-1:0]             uvFast,
	input  wire logic [NUM_CH-1:0]             adcBelowPgOn,
	input  wire logic [NUM_CH-1:0][CNT_W-1:0]  tonDelay,
	input  wire logic [NUM_CH-1:0][CNT_W-1:0]  tonRise,
	input  wire logic [NUM_CH-1:0][CNT_W-1:0]  tonMaxFault,
	input  wire logic [NUM_CH-1:0][CNT_W-1:0]  toffDelay,
	output logic [REG_W-1:0]                   cfgRdData,
	output logic [NUM_CH-1:0]                  trackRdData,
	output logic [NUM_CH-1:0]                  output_enable_pin,
	output logic [NUM_CH-1:0]                  uvUcMask,
	output logic [NUM_CH-1:0]                  pgood,
	output logic [NUM_CH-1:0]                  tonMaxFaultPulse
);
	// ==========================================
	// Pin synchronisers
	logic [2:0] pinRaw, pinSync;
	assign pinRaw = {shareClkPin, start_pin_3, start_pin_2};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			pin_sync u_sync (
				.core_clk (core_clk),
				.sys_rst  (sys_rst),
				.pinIn    (pinRaw[gi]),
				.pinOut   (pinSync[gi])
			);
		end
	endgenerate

	// ==========================================
	// Timebase divider
	logic [TICK_W-1:0] tickCnt_q, tickCnt_d;
	logic              tick_q, tick_d;
	always_comb begin
		tick_d    = (tickCnt_q == TICK_LAST);
		tickCnt_d = tick_d ? TICK_ZERO : tickCnt_q + 6'h01;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tickCnt_q <= TICK_ZERO;
			tick_q    <= 1'b0;
		end else begin
			tickCnt_q <= tickCnt_d;
			tick_q    <= tick_d;
		end
	end

	// ==========================================
	// Configuration registers
	logic [REG_W-1:0]  cfgAll_q, cfgAll_d, cfgRd_q, cfgRd_d;
	logic [NUM_CH-1:0] trackEn_q, trackEn_d, trackRd_q, trackRd_d;
	always_comb begin
		cfgAll_d  = cfgAll_q;
		trackEn_d = trackEn_q;
		// No page qualifier: common to every channel
		if (cfgWrEn) begin // RULE9
			cfgAll_d = cfgWrData & CFG_ALL_MASK; // RULE16
		end
		if (trackWrEn) begin
			trackEn_d = trackWrData; // RULE15
		end
		cfgRd_d = cfgAll_q;
		cfgRd_d[RSVD_HI_MSB:RSVD_HI_LSB] = 4'h0; // RULE10
		trackRd_d = trackEn_q;
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfgAll_q  <= CFG_ALL_RESET;
			trackEn_q <= TRACK_EN_RESET;
			cfgRd_q   <= CFG_ALL_RESET;
			trackRd_q <= TRACK_EN_RESET;
		end else begin
			cfgAll_q  <= cfgAll_d;
			trackEn_q <= trackEn_d;
			cfgRd_q   <= cfgRd_d;
			trackRd_q <= trackRd_d;
		end
	end

	// ==========================================
	// Start requests and shutdown events
	logic [NUM_CH-1:0] onReq;
	logic              shutdown;
	always_comb begin
		onReq = softOnReq;
		onReq[START2_CH] = softOnReq[START2_CH]
			& (pinSync[0] == cfgAll_q[POL2_BIT]); // RULE14
		onReq[START3_CH] = softOnReq[START3_CH]
			& (pinSync[1] == cfgAll_q[POL3_BIT]); // RULE13
		// A fault on any channel brings the whole group down together
		shutdown = (|chanFault) | vinOff | ~pinSync[2] | restoreAll;
	end

	// ==========================================
	// Channel sequencers
	chan_state_t [NUM_CH-1:0]      state_q, state_d;
	logic [NUM_CH-1:0][CNT_W-1:0]  cnt_q, cnt_d;
	logic [NUM_CH-1:0]             run_q, run_d, mask_q, mask_d;
	logic [NUM_CH-1:0]             pg_q, pg_d, tmf_q, tmf_d;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			state_d[c] = state_q[c];
			tmf_d[c]   = 1'b0;
			case (state_q[c])
				ST_OFF: begin
					if (onReq[c] && !shutdown) begin
						state_d[c] = ST_ON_DLY;
					end
				end
				ST_ON_DLY: begin
					if (!onReq[c] || shutdown) begin
						state_d[c] = ST_OFF;
					end else if (cnt_q[c] >= tonDelay[c]) begin
						state_d[c] = ST_RISE;
					end
				end
				ST_RISE, ST_MAX_WAIT, ST_ON: begin
					if (shutdown) begin
						// Cutting run early breaks the tracking order
						state_d[c] = trackEn_q[c] ? ST_OFF_DLY : ST_OFF; // RULE4
					end else if (!onReq[c]) begin
						state_d[c] = ST_OFF_DLY;
					end else if (state_q[c] == ST_RISE && cnt_q[c] >= tonRise[c]) begin
						state_d[c] = ST_MAX_WAIT;
					end else if (state_q[c] == ST_MAX_WAIT && voutAboveUv[c]) begin
						state_d[c] = ST_ON;
					end else if (state_q[c] == ST_MAX_WAIT && cnt_q[c] >= tonMaxFault[c]) begin
						tmf_d[c]   = 1'b1;
						state_d[c] = trackEn_q[c] ? ST_OFF_DLY : ST_OFF; // RULE4
					end
				end
				ST_OFF_DLY: begin
					if (cnt_q[c] >= toffDelay[c]) begin
						state_d[c] = ST_OFF;
					end
				end
				default: begin
					state_d[c] = ST_OFF;
				end
			endcase
			if (state_d[c] != state_q[c]) begin
				cnt_d[c] = CNT_ZERO;
			end else if (tick_q) begin
				cnt_d[c] = cnt_q[c] + CNT_ONE;
			end else begin
				cnt_d[c] = cnt_q[c];
			end
			// Run stays high through the off delay; the tracking input ramps it down
			run_d[c] = (state_d[c] == ST_RISE) || (state_d[c] == ST_MAX_WAIT)
				|| (state_d[c] == ST_ON) || (state_d[c] == ST_OFF_DLY); // RULE2
			mask_d[c] = (state_d[c] == ST_RISE) || (state_d[c] == ST_MAX_WAIT) // RULE6
				|| (state_d[c] == ST_OFF_DLY && trackEn_q[c]); // RULE5
			pg_d[c] = (state_q[c] == ST_ON) && (cfgAll_q[PGOOD_SRC_BIT]
				? !uvFast[c] // RULE12
				: !adcBelowPgOn[c]); // RULE11
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int c = 0; c < NUM_CH; c++) begin
				state_q[c] <= ST_OFF;
			end
			cnt_q   <= '0;
			run_q   <= '0;
			mask_q  <= '0;
			pg_q    <= '0;
			tmf_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			run_q   <= run_d;
			mask_q  <= mask_d;
			pg_q    <= pg_d;
			tmf_q   <= tmf_d;
		end
	end

	assign cfgRdData         = cfgRd_q;
	assign trackRdData       = trackRd_q;
	assign output_enable_pin = run_q;
	assign uvUcMask          = mask_q;
	assign pgood             = pg_q;
	assign tonMaxFaultPulse  = tmf_q;

	// ==========================================
	// Checks
	AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE10
		cfgRdData[RSVD_HI_MSB:RSVD_HI_LSB] == 4'h0)
		else $error("reserved configuration bits not zero");
	AST_CFG_READBACK: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE9
		cfgWrEn ##1 !cfgWrEn |-> ##1 (cfgRdData == ($past(cfgWrData, 2) & CFG_ALL_MASK)))
		else $error("configuration readback mismatch");
	AST_RSVD_IGNORED: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE16
		(cfgAll_q & ~CFG_ALL_MASK) == '0)
		else $error("reserved write stored");
	AST_POL3: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
		state_q[START3_CH] == ST_OFF ##1 state_q[START3_CH] == ST_ON_DLY
		|-> $past(pinSync[1]) == $past(cfgAll_q[POL3_BIT]))
		else $error("start pin 3 polarity ignored");
	AST_POL2: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
		state_q[START2_CH] == ST_OFF ##1 state_q[START2_CH] == ST_ON_DLY
		|-> $past(pinSync[0]) == $past(cfgAll_q[POL2_BIT]))
		else $error("start pin 2 polarity ignored");
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ast
			AST_RUN_HELD: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE2
				state_q[gi] == ST_OFF_DLY |-> run_q[gi])
				else $error("run dropped during off delay");
			AST_TRACK_DOWN: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
				shutdown && state_q[gi] == ST_ON && trackEn_q[gi] |=> state_q[gi] == ST_OFF_DLY)
				else $error("tracked channel was cut off");
			AST_UNTRACK_CUT: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
				shutdown && state_q[gi] == ST_ON && !trackEn_q[gi] |=> !run_q[gi])
				else $error("untracked channel not cut off");
			AST_MASK_OFF: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE5
				state_q[gi] == ST_OFF_DLY && trackEn_q[gi] |-> mask_q[gi])
				else $error("tracked off delay not masked");
			AST_MASK_RISE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
				(state_q[gi] == ST_RISE || state_q[gi] == ST_MAX_WAIT) |-> mask_q[gi])
				else $error("rise interval not masked");
			AST_PG_FAST: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE12
				cfgAll_q[PGOOD_SRC_BIT] && uvFast[gi] |=> !pg_q[gi])
				else $error("fast supervisor did not drop power good");
			AST_PG_ADC: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
				!cfgAll_q[PGOOD_SRC_BIT] && adcBelowPgOn[gi] |=> !pg_q[gi])
				else $error("converter compare did not drop power good");
		end
	endgenerate
endmodule // tracked_supply_sequencing

// ==== core/track_seq_pkg.sv ====
// Constants and types shared by the tracked supply sequencer
package track_seq_pkg;
	localparam int NUM_CH = 4;
	localparam int CNT_W = 16;
	localparam int REG_W = 16;
	// Chip-wide configuration field positions
	localparam int PGOOD_SRC_BIT = 11;
	localparam int POL3_BIT = 9;
	localparam int POL2_BIT = 8;
	localparam int RSVD_HI_MSB = 15;
	localparam int RSVD_HI_LSB = 12;
	localparam logic [REG_W-1:0] CFG_ALL_RESET = 16'h0000;
	localparam logic [REG_W-1:0] CFG_ALL_MASK = 16'h0B00;
	localparam logic [NUM_CH-1:0] TRACK_EN_RESET = 4'h0;
	localparam int START2_CH = 2;
	localparam int START3_CH = 3;
	// Timebase: one tick per microsecond
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W = 6;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [TICK_W-1:0] TICK_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_ON_DLY,
		ST_RISE,
		ST_MAX_WAIT,
		ST_ON,
		ST_OFF_DLY
	} chan_state_t;
endpackage

// ==== core/pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic pinIn,
	output logic      pinOut
);
	logic s1_q, s2_q, s3_q, out_q;
	logic out_d;

	// ==========================================
	// Filter
	always_comb begin
		// Only stages two and three are compared; stage one may be metastable
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			out_q <= 1'b0;
		end else begin
			s1_q  <= pinIn;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign pinOut = out_q;
endmodule // pin_sync

// ==== verification/converter_model.sv ====
// Behavioural model of tracking converters behind the run outputs
`timescale 1ns/1ps
module converter_model
	import track_seq_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire logic [NUM_CH-1:0] runEn,
	output logic      [NUM_CH-1:0] voutAboveUv
);
	// ==========================
	// Output ramps
	localparam int RAMP = 20;
	int level [NUM_CH];
	always_ff @(posedge core_clk or posedge sys_rst) begin
		for (int c = 0; c < NUM_CH; c++) begin
			if (sys_rst) begin
				level[c] <= 0;
			// Slaves rise only once the master is up, fall with it
			end else if (runEn[c] && (c == 0 || level[0] >= RAMP)) begin
				level[c] <= (level[c] < RAMP) ? level[c] + 1 : RAMP;
			end else begin
				level[c] <= (level[c] > 0) ? level[c] - 1 : 0;
			end
		end
	end
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			voutAboveUv[c] = (level[c] >= RAMP);
		end
	end
endmodule // converter_model

// ==== verification/test_tracked_supply_sequencing.sv ====
// Self-checking bench for the tracked supply sequencer
`timescale 1ns/1ps
module test_tracked_supply_sequencing
	import track_seq_pkg::*;
;
	// ==========================
	// Signals
	logic                         core_clk = 1'b0;
	logic                         sys_rst = 1'b1;
	logic                         cfgWrEn = 1'b0;
	logic [REG_W-1:0]             cfgWrData = 16'h0000;
	logic                         trackWrEn = 1'b0;
	logic [NUM_CH-1:0]            trackWrData = 4'h0;
	logic [NUM_CH-1:0]            softOnReq = 4'h0;
	logic                         shareClkPin = 1'b1;
	logic                         startPin2 = 1'b0;
	logic                         startPin3 = 1'b0;
	logic                         vinOff = 1'b0;
	logic                         restoreAll = 1'b0;
	logic [NUM_CH-1:0]            chanFault = 4'h0;
	logic [NUM_CH-1:0]            uvFast = 4'h0;
	logic [NUM_CH-1:0]            adcBelowPgOn = 4'h0;
	logic [NUM_CH-1:0][CNT_W-1:0] tonDelay, tonRise, tonMaxFault, toffDelay;
	logic [REG_W-1:0]             cfgRdData;
	logic [NUM_CH-1:0]            trackRdData, runOut, uvUcMask, pgood, voutAboveUv, maxPulse;
	int                           err_count = 0;
	int                           compares = 0;
	// Master on channel 0 starts last and stops first
	assign tonDelay = {16'h0001, 16'h0001, 16'h0001, 16'h0003};
	assign tonRise = {16'h0005, 16'h0005, 16'h0005, 16'h0002};
	assign tonMaxFault = {16'h0014, 16'h0014, 16'h0014, 16'h0014};
	assign toffDelay = {16'h0005, 16'h0005, 16'h0005, 16'h0002};
	always #10 core_clk = ~core_clk;
	tracked_supply_sequencing dut (
		.core_clk(core_clk), .sys_rst(sys_rst), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData),
		.trackWrEn(trackWrEn), .trackWrData(trackWrData), .softOnReq(softOnReq),
		.start_pin_2(startPin2), .start_pin_3(startPin3), .shareClkPin(shareClkPin),
		.vinOff(vinOff), .restoreAll(restoreAll), .chanFault(chanFault),
		.voutAboveUv(voutAboveUv), .uvFast(uvFast), .adcBelowPgOn(adcBelowPgOn),
		.tonDelay(tonDelay), .tonRise(tonRise), .tonMaxFault(tonMaxFault),
		.toffDelay(toffDelay), .cfgRdData(cfgRdData), .trackRdData(trackRdData),
		.output_enable_pin(runOut), .uvUcMask(uvUcMask), .pgood(pgood),
		.tonMaxFaultPulse(maxPulse)
	);
	converter_model partner (
		.core_clk(core_clk), .sys_rst(sys_rst), .runEn(runOut), .voutAboveUv(voutAboveUv)
	);
	// ==========================
	// Shared tasks
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic hang(input string what);
		err_count++;
		$display("BAD %s expected done seen timeout", what);
		conclude();
	endtask
	task automatic writeCfg(input logic [15:0] d);
		cfgWrData = d;
		cfgWrEn = 1'b1;
		@(negedge core_clk);
		cfgWrEn = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask
	task automatic powerUp();
		int i;
		softOnReq = 4'hF;
		for (i = 0; i < 1000 && runOut[0] !== 1'b1; i++) @(negedge core_clk);
		if (i == 1000) hang("master run");
		check("rise mask", uvUcMask, 4'hF);
		for (i = 0; i < 1000 && pgood !== 4'hF; i++) @(negedge core_clk);
		if (i == 1000) hang("pgood up");
	endtask
	task automatic powerDown();
		int i;
		softOnReq = 4'h0;
		for (i = 0; i < 1000 && runOut !== 4'h0; i++) @(negedge core_clk);
		if (i == 1000) hang("run off");
		check("idle mask", uvUcMask, 4'h0);
		repeat (4) @(negedge core_clk);
	endtask
	// ==========================
	// Scenarios
	task automatic pgoodSource();
		powerUp();
		uvFast = 4'hF;
		repeat (4) @(negedge core_clk);
		check("pgood slow source", pgood, 4'hF);
		adcBelowPgOn = 4'h2;
		repeat (4) @(negedge core_clk);
		check("pgood slow drop", pgood, 4'hD);
		writeCfg(16'h0800);
		check("pgood fast drop", pgood, 4'h0);
		{uvFast, adcBelowPgOn} = 8'h00;
		writeCfg(16'h0000);
		powerDown();
	endtask
	task automatic trackDown(input int code);
		powerUp();
		case (code)
			0: chanFault = 4'h2;
			1: vinOff = 1'b1;
			2: shareClkPin = 1'b0;
			default: restoreAll = 1'b1;
		endcase
		// Pin synchroniser needs a few edges
		repeat (8) @(negedge core_clk);
		check("run held", runOut, 4'hE);
		check("off delay mask", uvUcMask, 4'hE);
		repeat (150) @(negedge core_clk);
		check("run held late", runOut, 4'hE);
		{chanFault, vinOff, shareClkPin, restoreAll} = 7'h02;
		powerDown();
	endtask
	// Pins go inactive first so no start slips through the synchroniser
	task automatic startLevels();
		int i;
		startPin2 = 1'b1;
		startPin3 = 1'b1;
		repeat (8) @(negedge core_clk);
		softOnReq = 4'hC;
		repeat (150) @(negedge core_clk);
		check("start low active", runOut, 4'h0);
		writeCfg(16'h0200);
		repeat (150) @(negedge core_clk);
		check("start 3 high active", runOut, 4'h8);
		writeCfg(16'h0300);
		repeat (150) @(negedge core_clk);
		check("start 2 high active", runOut, 4'hC);
		// Master stays off, so the start pin 3 slave, started first, runs out of max-rise time
		for (i = 0; i < 2000 && maxPulse === 4'h0; i++) @(negedge core_clk);
		if (i == 2000) hang("max rise");
		check("max rise pulse", maxPulse, 4'h8);
		@(negedge core_clk);
		check("max rise pulse ends", maxPulse, 4'h0);
		check("max rise run held", runOut, 4'hC);
		check("max rise mask", uvUcMask, 4'hC);
		writeCfg(16'h0000);
		{startPin2, startPin3} = 2'b00;
		powerDown();
	endtask
	// Run last: leaves the start pin 2 level flipped
	task automatic regFields();
		writeCfg(16'hFFFF);
		check("cfg all ones", cfgRdData, 16'h0B00);
		writeCfg(16'hF4FF);
		check("cfg reserved only", cfgRdData, 16'h0000);
		writeCfg(16'h0200);
		check("cfg start 3 level", cfgRdData, 16'h0200);
		writeCfg(16'h0100);
		check("cfg start 2 level", cfgRdData, 16'h0100);
	endtask
	// ==========================
	// Main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (6) @(negedge core_clk);
		check("cfg reset", cfgRdData, CFG_ALL_RESET);
		check("track reset", trackRdData, TRACK_EN_RESET);
		trackWrData = 4'hE;
		trackWrEn = 1'b1;
		@(negedge core_clk);
		trackWrEn = 1'b0;
		repeat (3) @(negedge core_clk);
		check("track readback", trackRdData, 4'hE);
		pgoodSource();
		for (int k = 0; k < 4; k++) trackDown(k);
		startLevels();
		regFields();
		conclude();
	end
endmodule // test_tracked_supply_sequencing
